// ### hdl/sfc_pkg.sv
// Purpose: Shared constants, types and helpers of the serial frame and rate configuration block.
// Assumes: 32-bit register words on a plain strobe port, byte offsets as listed here.
// Notes:   Every offset, field position, reset value and code lives here once.

package sfc_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] SFC_OFS_CTRL     = 12'h000;
    localparam logic [11:0] SFC_OFS_PRESCALE = 12'h010;
    localparam logic [11:0] SFC_OFS_STATUS   = 12'h040;

    // ------------------------------------------------------------------
    // Field positions of the control word and the status busy bit
    // ------------------------------------------------------------------
    localparam int SFC_SCR_LSB   = 8;
    localparam int SFC_SCR_MSB   = 15;
    localparam int SFC_PHASE_BIT = 7;
    localparam int SFC_POL_BIT   = 6;
    localparam int SFC_FRF_LSB   = 4;
    localparam int SFC_FRF_MSB   = 5;
    localparam int SFC_DSS_LSB   = 0;
    localparam int SFC_DSS_MSB   = 3;
    localparam int SFC_BUSY_BIT  = 8;

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam logic [15:0] SFC_CTRL_RESET     = 16'h0000;
    localparam logic [7:0]  SFC_PRESCALE_RESET = 8'h02;

    // ------------------------------------------------------------------
    // Frame format codes and word size limit
    // ------------------------------------------------------------------
    localparam logic [1:0] SFC_FRF_STD   = 2'h0;
    localparam logic [1:0] SFC_FRF_PULSE = 2'h1;
    localparam logic [1:0] SFC_FRF_3WIRE = 2'h2;
    localparam logic [1:0] SFC_FRF_RSVD  = 2'h3;
    localparam logic [3:0] SFC_DSS_MIN   = 4'h3;

    // ------------------------------------------------------------------
    // Word engine states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SFC_IDLE  = 3'b001,
        SFC_LEAD  = 3'b010,
        SFC_TRAIL = 3'b100
    } sfc_state_t;

    // Word length in bits from the size code.
    function automatic logic [4:0] sfc_word_bits(input logic [3:0] word_size_field);
        sfc_word_bits = {1'b0, word_size_field} + 5'h01;
    endfunction

endpackage

// ### hdl/sfc_rate_gen.sv
// Purpose: Half-bit tick generator for the serial clock.
// Assumes: Prescale divisor is even, so half of it is exact.
// Notes:   One half bit lasts (prescale / 2) * (1 + rate) system clocks.

`timescale 1ns/1ps

module sfc_rate_gen
    import sfc_pkg::*;
#(
    parameter int PS_W  = 8,
    parameter int SCR_W = 8
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_reset,
    input  wire logic             i_restart,
    input  wire logic [PS_W-1:0]  i_prescale,
    input  wire logic [SCR_W-1:0] i_scr,
    output logic                  o_half_tick
);

    typedef struct packed {
        logic [PS_W-2:0] ps_cnt;
        logic [SCR_W-1:0] scr_cnt;
        logic             tick;
    } sfc_rate_t;

    sfc_rate_t       q;
    sfc_rate_t       next_q;
    logic [PS_W-2:0] half;

    // ------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------
    // A zero divisor would stall the clock forever, so it runs as two.
    always_comb begin
        half = i_prescale[PS_W-1:1];
        if (half == '0) begin
            half = {{(PS_W-2){1'b0}}, 1'b1};
        end
        next_q      = q;
        next_q.tick = 1'b0;
        if (i_restart) begin
            next_q.ps_cnt  = '0;
            next_q.scr_cnt = '0;
        end else if (q.ps_cnt == half - 1'b1) begin
            next_q.ps_cnt = '0;
            if (q.scr_cnt == i_scr) begin
                next_q.scr_cnt = '0;
                next_q.tick    = 1'b1; // R01
            end else begin
                next_q.scr_cnt = q.scr_cnt + 1'b1;
            end
        end else begin
            next_q.ps_cnt = q.ps_cnt + 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign o_half_tick = q.tick;

endmodule

// ### hdl/sfc_ctrl.sv
// Purpose: Frame and bit-rate configuration with the serial clock engine it steers.
// Assumes: Word start pulses come from framing logic on the same clock.
// Notes:   Shift and sample strobes feed shift registers that live elsewhere.
//
// Behaviour
// [R01] The bit rate is the system clock over prescale times one plus the rate field.
// [R02] Software keeps the prescale divisor even, from 2 to 254.
// [R03] In the standard format phase 0 samples on the first edge and 1 on the second.
// [R04] In the standard format polarity 0 idles the clock low and 1 idles it high.
// [R05] The format field picks standard, frame-pulse or three-wire; code 11 is reserved.
// [R06] The size field gives a word of the code plus one bits; codes under 3 are reserved.
// [R07] In slave use software sets the rate field to 0 and the prescale to 2.
// [R08] Software uses only full 32-bit word accesses.
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.

`timescale 1ns/1ps

module sfc_ctrl
    import sfc_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              i_clk_sys,
    input  wire logic              i_reset,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [31:0]       i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic [31:0]            o_rdata,
    input  wire logic              i_word_start,
    input  wire logic              i_word_abort,
    output logic                   o_serial_clock_pin,
    output logic                   o_sample_strobe,
    output logic                   o_shift_strobe,
    output logic                   o_word_done,
    output logic                   o_busy,
    output logic [4:0]             o_word_bits,
    output logic [1:0]             o_frame_format,
    output logic                   o_clock_phase_bit,
    output logic                   o_clock_polarity_bit,
    output logic                   o_format_reserved,
    output logic                   o_size_reserved
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] ctrl;
        logic [7:0]  prescale;
        sfc_state_t  state;
        logic        pin;
        logic [4:0]  bits_left;
        logic        sample;
        logic        shift;
        logic        done;
        logic [31:0] rdata;
    } sfc_regs_t;

    sfc_regs_t   q;
    sfc_regs_t   next_q;
    logic        half_tick;
    logic        restart;
    logic [7:0]  scr;
    logic [1:0]  frame_format_field;
    logic [3:0]  word_size_field;
    logic        phase;
    logic        idle_level;
    logic        sample_lead;
    logic [11:0] offset;

    // ------------------------------------------------------------------
    // Field views
    // ------------------------------------------------------------------
    assign scr    = q.ctrl[SFC_SCR_MSB:SFC_SCR_LSB];
    assign frame_format_field    = q.ctrl[SFC_FRF_MSB:SFC_FRF_LSB];
    assign word_size_field    = q.ctrl[SFC_DSS_MSB:SFC_DSS_LSB];
    assign phase  = q.ctrl[SFC_PHASE_BIT];
    assign offset = 12'(i_addr);

    // Phase and polarity only shape the standard format; the other
    // formats idle low and sample on the leading edge.
    always_comb begin
        if (frame_format_field == SFC_FRF_STD) begin
            idle_level  = q.ctrl[SFC_POL_BIT]; // R04
            sample_lead = ~phase;              // R03
        end else begin
            idle_level  = 1'b0;
            sample_lead = 1'b1;
        end
    end

    // The divider is held while no word runs, so every word starts
    // with a full half bit before the first edge.
    assign restart = (q.state == SFC_IDLE);

    sfc_rate_gen #(
        .PS_W  (8),
        .SCR_W (8)
    ) u_rate (
        .i_clk_sys   (i_clk_sys),
        .i_reset     (i_reset),
        .i_restart   (restart),
        .i_prescale  (q.prescale),
        .i_scr       (scr),
        .o_half_tick (half_tick)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_q        = q;
        next_q.sample = 1'b0;
        next_q.shift  = 1'b0;
        next_q.done   = 1'b0;
        next_q.rdata  = 32'h0000_0000;

        // Register writes; only the low half of the control word holds
        // state, the upper half is dropped.
        if (i_wr) begin
            case (offset)
                SFC_OFS_CTRL: begin
                    next_q.ctrl = i_wdata[15:0]; // R01
                end
                SFC_OFS_PRESCALE: begin
                    next_q.prescale = i_wdata[7:0]; // R02
                end
                default: begin
                    next_q.ctrl = q.ctrl;
                end
            endcase
        end

        // Register reads answer in the next cycle only.
        if (i_rd) begin
            case (offset)
                SFC_OFS_CTRL: begin
                    next_q.rdata = {16'h0000, q.ctrl};
                end
                SFC_OFS_PRESCALE: begin
                    next_q.rdata = {24'h00_0000, q.prescale};
                end
                SFC_OFS_STATUS: begin
                    next_q.rdata = {23'h00_0000, ~restart, 3'h0, q.bits_left};
                end
                default: begin
                    next_q.rdata = 32'h0000_0000;
                end
            endcase
        end

        // Word engine.
        case (q.state)
            SFC_IDLE: begin
                next_q.pin = idle_level; // R04
                if (i_word_start) begin
                    next_q.bits_left = sfc_word_bits(word_size_field); // R06
                    next_q.state     = SFC_LEAD;
                end
            end
            SFC_LEAD: begin
                if (i_word_abort) begin
                    next_q.state = SFC_IDLE;
                    next_q.pin   = idle_level;
                end else if (half_tick) begin
                    next_q.pin    = ~idle_level;
                    next_q.sample = sample_lead;  // R03
                    next_q.shift  = ~sample_lead; // R03
                    next_q.state  = SFC_TRAIL;
                end
            end
            SFC_TRAIL: begin
                if (i_word_abort) begin
                    next_q.state = SFC_IDLE;
                    next_q.pin   = idle_level;
                end else if (half_tick) begin
                    next_q.pin       = idle_level;
                    next_q.sample    = ~sample_lead; // R03
                    next_q.shift     = sample_lead;  // R03
                    next_q.bits_left = q.bits_left - 5'h01;
                    if (q.bits_left == 5'h01) begin
                        next_q.state = SFC_IDLE;
                        next_q.done  = 1'b1; // R06
                    end else begin
                        next_q.state = SFC_LEAD;
                    end
                end
            end
            default: begin
                next_q.state = SFC_IDLE;
                next_q.pin   = idle_level;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            q.ctrl      <= SFC_CTRL_RESET;
            q.prescale  <= SFC_PRESCALE_RESET;
            q.state     <= SFC_IDLE;
            q.pin       <= 1'b0;
            q.bits_left <= 5'h00;
            q.sample    <= 1'b0;
            q.shift     <= 1'b0;
            q.done      <= 1'b0;
            q.rdata     <= 32'h0000_0000;
        end else begin
            q <= next_q;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_rdata              = q.rdata;
    assign o_serial_clock_pin   = q.pin;
    assign o_sample_strobe      = q.sample;
    assign o_shift_strobe       = q.shift;
    assign o_word_done          = q.done;
    assign o_busy               = ~restart;
    assign o_word_bits          = sfc_word_bits(word_size_field); // R06
    assign o_frame_format       = frame_format_field; // R05
    assign o_clock_phase_bit    = phase;
    assign o_clock_polarity_bit = q.ctrl[SFC_POL_BIT];
    assign o_format_reserved    = (frame_format_field == SFC_FRF_RSVD); // R05
    assign o_size_reserved      = (word_size_field < SFC_DSS_MIN); // R06

endmodule

// ### verification/sfc_ctrl_sva.sv
// Purpose: Port checks for the frame and rate configuration block.
// Assumes: Software writes only even prescale values and no rate change mid-word.
// Notes:   Prescale and rate are mirrored from bus writes to predict the half bit.
`timescale 1ns/1ps
module sfc_ctrl_sva
    import sfc_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic              i_clk_sys,
    input wire logic              i_reset,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [31:0]       i_wdata,
    input wire logic              i_wr,
    input wire logic              i_word_abort,
    input wire logic              o_serial_clock_pin,
    input wire logic              o_sample_strobe,
    input wire logic              o_word_done,
    input wire logic              o_busy,
    input wire logic [4:0]        o_word_bits,
    input wire logic [1:0]        o_frame_format,
    input wire logic              o_clock_phase_bit,
    input wire logic              o_clock_polarity_bit,
    input wire logic              o_format_reserved,
    input wire logic              o_size_reserved
);
    logic [7:0]  ps;
    logic [7:0]  scr;
    logic [15:0] gap;
    logic [4:0]  cnt;
    logic        seen;
    logic        pin_q;
    wire logic        chg    = o_serial_clock_pin != pin_q;
    wire logic        wr_ctl = i_wr && i_addr == SFC_OFS_CTRL;
    wire logic [15:0] half   = 16'(ps >> 1) * (16'h0001 + 16'(scr));

    // The first edge of a word is not spaced from anything, so seen skips it.
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            ps    <= SFC_PRESCALE_RESET;
            scr   <= 8'h00;
            gap   <= 16'h0000;
            cnt   <= 5'h00;
            seen  <= 1'b0;
            pin_q <= 1'b0;
        end else begin
            if (i_wr && i_addr == SFC_OFS_PRESCALE) begin
                ps <= i_wdata[7:0];
            end
            if (wr_ctl) begin
                scr <= i_wdata[15:8];
            end
            pin_q <= o_serial_clock_pin;
            gap   <= chg ? 16'h0001 : gap + 16'h0001;
            seen  <= (i_word_abort || !o_busy) ? 1'b0 : (chg || seen);
            cnt   <= (o_word_done || i_word_abort) ? 5'h00 : cnt + 5'(o_sample_strobe);
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    AST_CFG_SIZE: assert property (wr_ctl |=> o_word_bits == 5'($past(i_wdata[3:0])) + 5'h01)
        else $error("word length not taken from size field");
    AST_CFG_MODE: assert property (wr_ctl |=>
        {o_clock_phase_bit, o_clock_polarity_bit, o_frame_format} == $past(i_wdata[7:4]))
        else $error("phase, polarity or format not taken from write");
    AST_FMT_RSVD: assert property (o_format_reserved == (o_frame_format == SFC_FRF_RSVD))
        else $error("reserved format flag wrong");
    AST_SIZE_RSVD: assert property (o_size_reserved == (o_word_bits < 5'h04))
        else $error("reserved size flag wrong");
    AST_IDLE: assert property (!o_busy && $past(!o_busy) &&
        $stable({o_clock_polarity_bit, o_frame_format}) |->
        o_serial_clock_pin == (o_frame_format == SFC_FRF_STD && o_clock_polarity_bit))
        else $error("serial clock not at idle level");
    AST_SAMPLE_LVL: assert property (o_sample_strobe && o_frame_format == SFC_FRF_STD |->
        chg && o_serial_clock_pin == (o_clock_polarity_bit ^ !o_clock_phase_bit))
        else $error("sample strobe on wrong clock edge");
    AST_BIT_COUNT: assert property (o_word_done |-> cnt + 5'(o_sample_strobe) == o_word_bits)
        else $error("sample count differs from word length");
    AST_HALF: assert property (chg && seen |-> gap == half)
        else $error("serial clock half period wrong");

    cover property (o_word_done && o_clock_phase_bit);
    cover property (o_word_done && o_frame_format == SFC_FRF_3WIRE);
    cover property (i_word_abort && o_busy);
endmodule

// ### verification/sfc_periph.sv
// Purpose: Far-side serial peripheral that watches the serial clock.
// Assumes: The clock is sampled on the system clock, one cycle late.
// Notes:   Counts clock edges per word and keeps the last edge spacing.
`timescale 1ns/1ps
module sfc_periph (
    input  wire logic        i_clk_sys,
    input  wire logic        i_clear,
    input  wire logic        i_sclk,
    output logic [7:0]       o_edges,
    output logic [15:0]      o_gap
);
    logic        last = 1'b0;
    logic [15:0] run  = 16'h0000;
    initial o_edges = 8'h00;
    initial o_gap = 16'h0000;
    always @(posedge i_clk_sys) begin
        last <= i_sclk;
        run  <= (i_sclk != last) ? 16'h0001 : run + 16'h0001;
        if (i_clear) begin
            o_edges <= 8'h00;
        end else if (i_sclk != last) begin
            o_edges <= o_edges + 8'h01;
            o_gap   <= run;
        end
    end
endmodule

// ### verification/tb.sv
// Purpose: Self-checking bench for the frame and rate configuration block.
// Assumes: Register port with one-cycle strobes, read data one cycle later.
// Notes:   Words run with short divisors so the whole run stays brief.
`timescale 1ns/1ps
module tb;
    import sfc_pkg::*;
    logic        i_clk_sys = 1'b0;
    logic        i_reset = 1'b1;
    logic [11:0] i_addr = 12'h000;
    logic [31:0] i_wdata = 32'h0;
    logic        i_wr = 1'b0, i_rd = 1'b0, i_word_start = 1'b0, i_word_abort = 1'b0;
    logic        p_clr = 1'b0;
    logic [31:0] o_rdata;
    logic        o_serial_clock_pin, o_sample_strobe, o_shift_strobe, o_word_done, o_busy;
    logic        o_clock_phase_bit, o_clock_polarity_bit, o_format_reserved, o_size_reserved;
    logic [4:0]  o_word_bits;
    logic [1:0]  o_frame_format;
    logic [7:0]  p_edges;
    logic [15:0] p_gap;
    int          err_total = 0, num_checks = 0;

    always #2 i_clk_sys = ~i_clk_sys;

    sfc_ctrl sfc_ctrl_i (.i_clk_sys, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_word_start, .i_word_abort, .o_serial_clock_pin, .o_sample_strobe, .o_shift_strobe,
        .o_word_done, .o_busy, .o_word_bits, .o_frame_format, .o_clock_phase_bit,
        .o_clock_polarity_bit, .o_format_reserved, .o_size_reserved);
    sfc_periph sfc_periph_i (.i_clk_sys, .i_clear(p_clr), .i_sclk(o_serial_clock_pin),
        .o_edges(p_edges), .o_gap(p_gap));

    task automatic test_done();
        if (err_total == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask
    task automatic t_reset();
        logic [31:0] d;
        rd(SFC_OFS_CTRL, d);
        chk(d, 32'h0);
        chk({27'h0, o_word_bits}, 32'h1);
        rd(SFC_OFS_PRESCALE, d);
        chk(d, 32'h2);
    endtask
    task automatic t_regs();
        logic [31:0] d;
        wr(SFC_OFS_CTRL, 32'h0000_0347);
        rd(SFC_OFS_CTRL, d);
        chk(d, 32'h0000_0347);
        chk({27'h0, o_word_bits}, 32'h8);
        for (int f = 0; f < 4; f++) begin
            wr(SFC_OFS_CTRL, 32'(f << 4) | 32'h2);
            #1;
            chk(o_frame_format, f[1:0]);
            chk(o_format_reserved, f == 3);
            chk(o_size_reserved, 1'b1);
        end
        rd(12'h020, d);
        chk(d, 32'h0);
    endtask
    task automatic t_word(input logic [15:0] cfg, input logic [7:0] ps);
        int n, s, h;
        logic [31:0] b;
        b = {28'h0, cfg[3:0]} + 32'h1;
        wr(SFC_OFS_PRESCALE, {24'h0, ps});
        wr(SFC_OFS_CTRL, {16'h0, cfg});
        @(posedge i_clk_sys);
        i_word_start <= 1'b1;
        p_clr <= 1'b1;
        @(posedge i_clk_sys);
        i_word_start <= 1'b0;
        p_clr <= 1'b0;
        n = 0;
        s = 0;
        h = 0;
        do begin
            @(posedge i_clk_sys);
            #1;
            n++;
            s += o_sample_strobe;
            h += o_shift_strobe;
        end while (o_word_done !== 1'b1 && n < 5000);
        chk(o_word_done, 1'b1);
        chk(s, b);
        chk(h, b);
        @(posedge i_clk_sys);
        #1;
        chk({24'h0, p_edges}, b << 1);
        chk({16'h0, p_gap}, (ps >> 1) * (1 + cfg[15:8]));
        chk(o_serial_clock_pin, cfg[5:4] == 2'h0 && cfg[6]);
    endtask
    task automatic t_abort();
        logic [31:0] d;
        wr(SFC_OFS_CTRL, 32'h0000_034f);
        wr(SFC_OFS_PRESCALE, 32'h0000_0002);
        @(posedge i_clk_sys);
        i_word_start <= 1'b1;
        @(posedge i_clk_sys);
        i_word_start <= 1'b0;
        rd(SFC_OFS_STATUS, d);
        chk(d, 32'h0000_0110);
        // Abort while the clock sits at its active level, so a dead abort path shows.
        repeat (4) @(posedge i_clk_sys);
        i_word_abort <= 1'b1;
        @(posedge i_clk_sys);
        i_word_abort <= 1'b0;
        #1;
        chk(o_serial_clock_pin, 1'b1);
        chk(o_busy, 1'b0);
    endtask

    initial begin
        repeat (10) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        t_reset();
        t_regs();
        t_word(16'h0003, 8'h02);
        t_word(16'h02cf, 8'h04);
        t_word(16'h0017, 8'h02);
        t_word(16'h0125, 8'h06);
        t_abort();
        test_done();
    end
    // Whole run needs a few hundred cycles; this leaves a wide margin.
    initial begin
        #100000;
        err_total++;
        test_done();
    end
endmodule

bind sfc_ctrl sfc_ctrl_sva #(.ADDR_W(ADDR_W)) sfc_ctrl_sva_i (.i_clk_sys, .i_reset, .i_addr,
    .i_wdata, .i_wr, .i_word_abort, .o_serial_clock_pin, .o_sample_strobe, .o_word_done,
    .o_busy, .o_word_bits, .o_frame_format, .o_clock_phase_bit, .o_clock_polarity_bit,
    .o_format_reserved, .o_size_reserved);
